// ---- rtl/flh_fault_log.sv ----
`timescale 1ns/10ps
// How it works
// - enabled faults stay latched until reset action
// - latch raises faulted, which forces coast stop
// - first fault only snapshots status, alarms, speed, amps, volts
// - faulted depends on latches only, not queue
// - no new entry while a fault latched
// - entry holds fault code and time stamp
// - new entry at position one, others shift deeper
// - full queue drops its oldest entry
// - queue copied to nonvolatile store on power loss
// - each position code readable as numeric value
// - peripheral sees fault as 16-char text
// - stamp equals powered-time timer at logging
// - power-up copies timer into power-on snapshot
// - 32-bit wrapping timer, 0.35 s tick, not writable
// - stamp readable in hours, four decimals
// - clear on input edge, param, peripheral, defaults, power-up
// - reset clears faulted; persisting fault relatches, logs
// - fault reset leaves queue; separate queue clear
// - 16-bit mask enables faults, hides disabled ones
module flh_fault_log #(
  parameter logic [31:0] TICK_CYCLES = 32'(flh_pkg::TICK_CYCLES)
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic [flh_pkg::FAULT_BITS-1:0] fault_cond,
  input  wire logic [flh_pkg::FAULT_BITS-1:0] fault_enable_mask,
  input  wire logic [flh_pkg::DATA_W-1:0]     drive_status1,
  input  wire logic [flh_pkg::DATA_W-1:0]     drive_status2,
  input  wire logic [flh_pkg::DATA_W-1:0]     alarm_status1,
  input  wire logic [flh_pkg::DATA_W-1:0]     alarm_status2,
  input  wire logic [flh_pkg::DATA_W-1:0]     drive_speed,
  input  wire logic [flh_pkg::DATA_W-1:0]     motor_current,
  input  wire logic [flh_pkg::DATA_W-1:0]     bus_volts_raw,
  input  wire logic                           reset_input,
  input  wire logic                           fault_clear_wr,
  input  wire logic                           fault_clear_wdata,
  input  wire logic                           peripheral_port_reset,
  input  wire logic                           factory_default_req,
  input  wire logic                           queue_clear_req,
  input  wire logic                           power_loss,
  input  wire logic                           nv_restore_valid,
  input  wire logic [flh_pkg::POS_W-1:0]      nv_restore_pos,
  input  wire logic [flh_pkg::CODE_W-1:0]     nv_restore_code,
  input  wire logic [flh_pkg::STAMP_W-1:0]    nv_restore_stamp,
  input  wire logic                           nv_restore_used,
  input  wire logic                           nv_timer_restore_valid,
  input  wire logic [flh_pkg::STAMP_W-1:0]    nv_timer_restore_value,
  input  wire logic [flh_pkg::POS_W-1:0]      read_pos,
  output logic                                faulted,
  output logic                                coast_stop,
  output logic [flh_pkg::FAULT_BITS-1:0]      latched_faults,
  output logic [flh_pkg::DATA_W-1:0]          ctx_status1,
  output logic [flh_pkg::DATA_W-1:0]          ctx_status2,
  output logic [flh_pkg::DATA_W-1:0]          ctx_alarm1,
  output logic [flh_pkg::DATA_W-1:0]          ctx_alarm2,
  output logic [flh_pkg::DATA_W-1:0]          ctx_speed,
  output logic [flh_pkg::DATA_W-1:0]          ctx_current,
  output logic [flh_pkg::DATA_W-1:0]          ctx_bus_volts,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_1,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_2,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_3,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_4,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_5,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_6,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_7,
  output logic [flh_pkg::CODE_W-1:0]          queue_code_8,
  output logic [flh_pkg::CODE_W-1:0]          read_code,
  output logic [flh_pkg::STAMP_W-1:0]         read_stamp,
  output logic [flh_pkg::STAMP_W-1:0]         read_stamp_hours,
  output logic                                read_used,
  output logic [flh_pkg::TEXT_W-1:0]          read_text,
  output logic [flh_pkg::STAMP_W-1:0]         powered_time,
  output logic [flh_pkg::STAMP_W-1:0]         power_on_time_snapshot,
  output logic                                nv_save_valid,
  output logic [flh_pkg::POS_W-1:0]           nv_save_pos,
  output logic [flh_pkg::CODE_W-1:0]          nv_save_code,
  output logic [flh_pkg::STAMP_W-1:0]         nv_save_stamp,
  output logic                                nv_save_used,
  output logic                                nv_save_done
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // lowest set source wins when several trip together; code is index+1
  function automatic logic [flh_pkg::CODE_W-1:0] first_code(
    input logic [flh_pkg::FAULT_BITS-1:0] hits
  );
    logic [flh_pkg::CODE_W-1:0] c;
    c = flh_pkg::CODE_RST;
    for (int i = flh_pkg::FAULT_BITS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        c = 8'(i + 1);
      end
    end
    return c;
  endfunction : first_code

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  function automatic logic [flh_pkg::TEXT_W-1:0] code_text(
    input logic                        used,
    input logic [flh_pkg::CODE_W-1:0]  code
  );
    if (!used) begin
      return "No fault        ";
    end
    return {"Fault code 0x", hex_char(code[7:4]), hex_char(code[3:0]), " "};
  endfunction : code_text

  // divide by a constant; one instance only, on the read path
  function automatic logic [flh_pkg::STAMP_W-1:0] to_hours(
    input logic [flh_pkg::STAMP_W-1:0] t
  );
    logic [flh_pkg::STAMP_W+5:0] p;
    p = {6'h00, t} * 38'(flh_pkg::HOURS_NUM);
    return 32'(p / 38'(flh_pkg::HOURS_DEN));
  endfunction : to_hours

  // ****************************************************************
  // powered-time timer and power-on snapshot
  // ****************************************************************
  logic [31:0]                  tick_cnt_q, tick_cnt_d;
  logic [flh_pkg::STAMP_W-1:0]  timer_q, timer_d;
  logic [flh_pkg::STAMP_W-1:0]  snap_q, snap_d;
  logic                         pu_pending_q, pu_pending_d;

  // no user write path exists; only the nonvolatile restore loads it
  always_comb begin
    tick_cnt_d   = tick_cnt_q + 32'h0000_0001;
    timer_d      = timer_q;
    snap_d       = snap_q;
    pu_pending_d = 1'b0;
    if (tick_cnt_q >= TICK_CYCLES - 32'h0000_0001) begin
      tick_cnt_d = 32'h0000_0000;
      timer_d    = timer_q + 32'h0000_0001;                  // wraps to zero
    end
    if (nv_timer_restore_valid) begin
      timer_d = nv_timer_restore_value;
      snap_d  = nv_timer_restore_value;
    end else if (pu_pending_q) begin
      snap_d  = timer_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q   <= 32'h0000_0000;
      timer_q      <= flh_pkg::STAMP_RST;
      snap_q       <= flh_pkg::STAMP_RST;
      pu_pending_q <= 1'b1;
    end else begin
      tick_cnt_q   <= tick_cnt_d;
      timer_q      <= timer_d;
      snap_q       <= snap_d;
      pu_pending_q <= pu_pending_d;
    end
  end

  assign powered_time           = timer_q;
  assign power_on_time_snapshot = snap_q;

  // ****************************************************************
  // fault latch, context and history queue
  // ****************************************************************
  logic [flh_pkg::FAULT_BITS-1:0] latch_q, latch_d;
  logic                           rin_q;
  logic [flh_pkg::DATA_W-1:0]     ctx_q [7];
  logic [flh_pkg::DATA_W-1:0]     ctx_d [7];
  logic [flh_pkg::CODE_W-1:0]     code_q [flh_pkg::QUEUE_DEPTH];
  logic [flh_pkg::CODE_W-1:0]     code_d [flh_pkg::QUEUE_DEPTH];
  logic [flh_pkg::STAMP_W-1:0]    stamp_q [flh_pkg::QUEUE_DEPTH];
  logic [flh_pkg::STAMP_W-1:0]    stamp_d [flh_pkg::QUEUE_DEPTH];
  logic [flh_pkg::QUEUE_DEPTH-1:0] used_q, used_d;
  logic [flh_pkg::FAULT_BITS-1:0] hits;
  logic                           any_latched;
  logic                           fault_reset;
  logic                           push;

  assign hits        = fault_cond & fault_enable_mask;
  assign any_latched = |(latch_q & fault_enable_mask);
  // power-up clearing is done by rst itself
  assign fault_reset = (reset_input & ~rin_q)
                     | (fault_clear_wr & fault_clear_wdata)
                     | peripheral_port_reset
                     | factory_default_req;
  // a fault present in the reset cycle relatches and logs at once
  assign push        = (fault_reset | ~any_latched) & (|hits);

  always_comb begin
    ctx_d   = ctx_q;
    code_d  = code_q;
    stamp_d = stamp_q;
    used_d  = used_q;
    latch_d = fault_reset ? hits : (latch_q | hits);
    if (nv_restore_valid) begin
      code_d[nv_restore_pos]  = nv_restore_code;
      stamp_d[nv_restore_pos] = nv_restore_stamp;
      used_d[nv_restore_pos]  = nv_restore_used;
    end
    // queue clear empties all positions; codes read back as zero
    if (queue_clear_req) begin
      used_d = '0;
      code_d = '{default: flh_pkg::CODE_RST};
    end
    // push after clear so a same-cycle fault is not lost
    if (push) begin
      for (int i = flh_pkg::QUEUE_DEPTH - 1; i > 0; i--) begin
        code_d[i]  = code_d[i-1];
        stamp_d[i] = stamp_d[i-1];
        used_d[i]  = used_d[i-1];
      end
      code_d[0]  = first_code(hits);
      stamp_d[0] = timer_q;
      used_d[0]  = 1'b1;
      ctx_d[0] = drive_status1;
      ctx_d[1] = drive_status2;
      ctx_d[2] = alarm_status1;
      ctx_d[3] = alarm_status2;
      ctx_d[4] = drive_speed;
      ctx_d[5] = motor_current;
      ctx_d[6] = bus_volts_raw;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_q <= flh_pkg::LATCH_RST;
      rin_q   <= 1'b0;
      used_q  <= '0;
      for (int i = 0; i < 7; i++) begin
        ctx_q[i] <= flh_pkg::DATA_RST;
      end
      for (int i = 0; i < flh_pkg::QUEUE_DEPTH; i++) begin
        code_q[i]  <= flh_pkg::CODE_RST;
        stamp_q[i] <= flh_pkg::STAMP_RST;
      end
    end else begin
      latch_q <= latch_d;
      rin_q   <= reset_input;
      used_q  <= used_d;
      ctx_q   <= ctx_d;
      code_q  <= code_d;
      stamp_q <= stamp_d;
    end
  end

  // faulted ignores queue state entirely
  assign faulted        = any_latched;
  assign coast_stop     = any_latched;
  assign latched_faults = latch_q & fault_enable_mask;
  assign ctx_status1    = ctx_q[0];
  assign ctx_status2    = ctx_q[1];
  assign ctx_alarm1     = ctx_q[2];
  assign ctx_alarm2     = ctx_q[3];
  assign ctx_speed      = ctx_q[4];
  assign ctx_current    = ctx_q[5];
  assign ctx_bus_volts  = ctx_q[6];
  // one numeric code port per position
  assign queue_code_1   = code_q[0];
  assign queue_code_2   = code_q[1];
  assign queue_code_3   = code_q[2];
  assign queue_code_4   = code_q[3];
  assign queue_code_5   = code_q[4];
  assign queue_code_6   = code_q[5];
  assign queue_code_7   = code_q[6];
  assign queue_code_8   = code_q[7];

  // ****************************************************************
  // read port for stamps and peripheral text
  // ****************************************************************
  logic [flh_pkg::CODE_W-1:0]  rd_code_q, rd_code_d;
  logic [flh_pkg::STAMP_W-1:0] rd_stamp_q, rd_stamp_d;
  logic [flh_pkg::STAMP_W-1:0] rd_hours_q, rd_hours_d;
  logic                        rd_used_q, rd_used_d;
  logic [flh_pkg::TEXT_W-1:0]  rd_text_q, rd_text_d;

  // one cycle of latency keeps the divider off the output pins
  always_comb begin
    rd_code_d  = code_q[read_pos];
    rd_stamp_d = stamp_q[read_pos];
    rd_hours_d = to_hours(stamp_q[read_pos]);
    rd_used_d  = used_q[read_pos];
    rd_text_d  = code_text(used_q[read_pos], code_q[read_pos]);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_code_q  <= flh_pkg::CODE_RST;
      rd_stamp_q <= flh_pkg::STAMP_RST;
      rd_hours_q <= flh_pkg::STAMP_RST;
      rd_used_q  <= 1'b0;
      rd_text_q  <= '0;
    end else begin
      rd_code_q  <= rd_code_d;
      rd_stamp_q <= rd_stamp_d;
      rd_hours_q <= rd_hours_d;
      rd_used_q  <= rd_used_d;
      rd_text_q  <= rd_text_d;
    end
  end

  assign read_code        = rd_code_q;
  assign read_stamp       = rd_stamp_q;
  assign read_stamp_hours = rd_hours_q;
  assign read_used        = rd_used_q;
  assign read_text        = rd_text_q;

  // ****************************************************************
  // nonvolatile save on power loss
  // ****************************************************************
  flh_pkg::flh_save_st_t       st_q, st_d;
  logic [flh_pkg::POS_W-1:0]   sv_pos_q, sv_pos_d;
  logic                        sv_valid_q, sv_valid_d;
  logic [flh_pkg::CODE_W-1:0]  sv_code_q, sv_code_d;
  logic [flh_pkg::STAMP_W-1:0] sv_stamp_q, sv_stamp_d;
  logic                        sv_used_q, sv_used_d;
  logic [flh_pkg::POS_W-1:0]   sv_pos_out_q;

  // walks positions 1..8, one per cycle; live queue is sampled as it goes
  always_comb begin
    st_d       = st_q;
    sv_pos_d   = sv_pos_q;
    sv_valid_d = 1'b0;
    sv_code_d  = sv_code_q;
    sv_stamp_d = sv_stamp_q;
    sv_used_d  = sv_used_q;
    case (st_q)
      flh_pkg::ST_IDLE: begin
        if (power_loss) begin
          st_d     = flh_pkg::ST_SAVE;
          sv_pos_d = flh_pkg::POS_RST;
        end
      end
      flh_pkg::ST_SAVE: begin
        sv_valid_d = 1'b1;
        sv_code_d  = code_q[sv_pos_q];
        sv_stamp_d = stamp_q[sv_pos_q];
        sv_used_d  = used_q[sv_pos_q];
        if (sv_pos_q == flh_pkg::POS_LAST) begin
          st_d = flh_pkg::ST_DONE;
        end else begin
          sv_pos_d = sv_pos_q + 3'h1;
        end
      end
      flh_pkg::ST_DONE: begin
        st_d = flh_pkg::ST_IDLE;
      end
      default: begin
        st_d = flh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q       <= flh_pkg::ST_IDLE;
      sv_pos_q   <= flh_pkg::POS_RST;
      sv_valid_q <= 1'b0;
      sv_code_q  <= flh_pkg::CODE_RST;
      sv_stamp_q <= flh_pkg::STAMP_RST;
      sv_used_q  <= 1'b0;
      sv_pos_out_q <= flh_pkg::POS_RST;
    end else begin
      st_q       <= st_d;
      sv_pos_q   <= sv_pos_d;
      sv_valid_q <= sv_valid_d;
      sv_code_q  <= sv_code_d;
      sv_stamp_q <= sv_stamp_d;
      sv_used_q  <= sv_used_d;
      sv_pos_out_q <= sv_pos_q;                                   // lines up with entry data
    end
  end

  assign nv_save_valid = sv_valid_q;
  assign nv_save_pos   = sv_pos_out_q;
  assign nv_save_code  = sv_code_q;
  assign nv_save_stamp = sv_stamp_q;
  assign nv_save_used  = sv_used_q;
  assign nv_save_done  = (st_q == flh_pkg::ST_DONE);

endmodule : flh_fault_log

// ---- rtl/flh_pkg.sv ----
package flh_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned QUEUE_DEPTH = 8;   // history positions
  localparam int unsigned POS_W       = 3;   // position index width
  localparam int unsigned FAULT_BITS  = 16;  // configurable fault sources
  localparam int unsigned CODE_W      = 8;   // numeric fault code width
  localparam int unsigned STAMP_W     = 32;  // powered-time accumulator width
  localparam int unsigned DATA_W      = 16;  // context word width
  localparam int unsigned TEXT_CHARS  = 16;  // peripheral text length
  localparam int unsigned TEXT_W      = TEXT_CHARS * 8;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_KHZ  = 40000;  // 40 MHz system clock
  localparam int unsigned TICK_TIME_MS = 350;    // powered-time resolution
  localparam int unsigned TICK_CYCLES  = TICK_TIME_MS * SYS_CLK_KHZ;
  // stamp in 0.0001 h units: ticks * 0.35 s / 0.36 s
  localparam int unsigned HOURS_NUM    = 35;
  localparam int unsigned HOURS_DEN    = 36;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [FAULT_BITS-1:0] LATCH_RST = 16'h0000;
  localparam logic [CODE_W-1:0]     CODE_RST  = 8'h00;
  localparam logic [STAMP_W-1:0]    STAMP_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0]     DATA_RST  = 16'h0000;
  localparam logic [POS_W-1:0]      POS_RST   = 3'h0;
  localparam logic [POS_W-1:0]      POS_LAST  = 3'h7;

  // ****************************************************************
  // nonvolatile save sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_DONE = 2'b10
  } flh_save_st_t;

endpackage : flh_pkg

// ---- test/flh_fault_log_chk.sv ----
`timescale 1ns/10ps
module flh_fault_log_chk (
  input wire logic                           sys_clk,
  input wire logic                           rst,
  input wire logic [flh_pkg::FAULT_BITS-1:0] fault_cond,
  input wire logic [flh_pkg::FAULT_BITS-1:0] fault_enable_mask,
  input wire logic                           reset_input,
  input wire logic                           fault_clear_wr,
  input wire logic                           fault_clear_wdata,
  input wire logic                           peripheral_port_reset,
  input wire logic                           factory_default_req,
  input wire logic                           queue_clear_req,
  input wire logic                           power_loss,
  input wire logic                           faulted,
  input wire logic                           coast_stop,
  input wire logic [flh_pkg::FAULT_BITS-1:0] latched_faults,
  input wire logic [flh_pkg::CODE_W-1:0]     queue_code_1,
  input wire logic [flh_pkg::CODE_W-1:0]     queue_code_2,
  input wire logic                           nv_save_valid,
  input wire logic                           nv_save_done
);
  // ********************
  // helpers and properties
  // ********************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] hits;
  logic        rin_q;
  logic        clr;
  // only a rising edge of the reset input counts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) rin_q <= 1'b0;
    else rin_q <= reset_input;
  end
  assign hits = fault_cond & fault_enable_mask;
  assign clr = (reset_input & ~rin_q) | (fault_clear_wr & fault_clear_wdata)
             | peripheral_port_reset | factory_default_req;
  // lowest set source wins when several trip together
  function automatic logic [7:0] low_code(input logic [15:0] h);
    low_code = 8'h00;
    for (int i = 15; i >= 0; i--) if (h[i]) low_code = 8'(i + 1);
  endfunction : low_code
  sequence push_now;
    (!faulted || clr) && (|hits) && !queue_clear_req;
  endsequence
  sequence save_run;
    nv_save_valid [*7] ##1 (nv_save_valid && nv_save_done);
  endsequence
  a_fault_latches: assert property ((|hits) |=> faulted)
    else $error("enabled fault did not latch");
  a_coast_follow: assert property (coast_stop == faulted)
    else $error("coast stop differs from faulted");
  a_faulted_latch: assert property (faulted == (|latched_faults))
    else $error("faulted not tied to latches");
  a_mask_hides: assert property ((latched_faults & ~fault_enable_mask) == 16'h0000)
    else $error("masked fault visible");
  a_latch_holds: assert property ((faulted && !clr) ##1 $stable(fault_enable_mask) |-> faulted)
    else $error("latch dropped without reset");
  a_no_relog: assert property ((faulted && !clr && !queue_clear_req) |=>
    $stable(queue_code_1) && $stable(queue_code_2))
    else $error("entry logged while latched");
  a_push_shift: assert property (push_now |=> queue_code_2 == $past(queue_code_1))
    else $error("queue did not shift");
  a_code_value: assert property (push_now |=> queue_code_1 == low_code($past(hits)))
    else $error("wrong fault code logged");
  a_clear_drops: assert property ((clr && !(|hits)) |=> !faulted)
    else $error("reset did not clear faulted");
  a_save_walk: assert property ((power_loss && !nv_save_valid && !nv_save_done) |->
    ##2 save_run)
    else $error("save walk wrong");
endmodule : flh_fault_log_chk

bind flh_fault_log flh_fault_log_chk u_chk (
  .sys_clk, .rst, .fault_cond, .fault_enable_mask, .reset_input, .fault_clear_wr,
  .fault_clear_wdata, .peripheral_port_reset, .factory_default_req, .queue_clear_req,
  .power_loss, .faulted, .coast_stop, .latched_faults, .queue_code_1, .queue_code_2,
  .nv_save_valid, .nv_save_done
);

// ---- test/flh_nv_model.sv ----
`timescale 1ns/10ps
module flh_nv_model (
  input  wire logic                        sys_clk,
  input  wire logic                        replay,
  input  wire logic                        nv_save_valid,
  input  wire logic [flh_pkg::POS_W-1:0]   nv_save_pos,
  input  wire logic [flh_pkg::CODE_W-1:0]  nv_save_code,
  input  wire logic [flh_pkg::STAMP_W-1:0] nv_save_stamp,
  input  wire logic                        nv_save_used,
  output logic                             nv_restore_valid,
  output logic [flh_pkg::POS_W-1:0]        nv_restore_pos,
  output logic [flh_pkg::CODE_W-1:0]       nv_restore_code,
  output logic [flh_pkg::STAMP_W-1:0]      nv_restore_stamp,
  output logic                             nv_restore_used
);
  // ********************
  // nonvolatile store
  // ********************
  logic [7:0]  code_m [8];
  logic [31:0] stamp_m [8];
  logic        used_m [8];
  int          n = 8;
  initial {nv_restore_valid, nv_restore_pos, nv_restore_code, nv_restore_stamp} = 44'h0;
  initial nv_restore_used = 1'b0;
  // keep every walked entry so it survives the power cycle
  always @(posedge sys_clk) begin
    if (nv_save_valid) begin
      code_m[nv_save_pos] <= nv_save_code;
      stamp_m[nv_save_pos] <= nv_save_stamp;
      used_m[nv_save_pos] <= nv_save_used;
    end
  end
  // replay one entry a cycle; idle code and stamp lines toggle so stale data never looks valid
  always @(negedge sys_clk) begin
    if (replay && n == 8) n = 0;
    nv_restore_valid <= (n < 8);
    if (n < 8) begin
      nv_restore_pos <= 3'(n);
      nv_restore_code <= code_m[n];
      nv_restore_stamp <= stamp_m[n];
      nv_restore_used <= used_m[n];
      n = n + 1;
    end else begin
      nv_restore_code <= ~nv_restore_code;
      nv_restore_stamp <= ~nv_restore_stamp;
    end
  end
endmodule : flh_nv_model

// ---- test/tb.sv ----
`timescale 1ns/10ps
module tb;
  // ********************
  // stimulus and checks
  // ********************
  logic [15:0]  fault_cond = 16'h0000, mask = 16'hFFFF, ctxb = 16'h1000, cb;
  logic         sys_clk = 1'b0, rst = 1'b1, rin = 1'b0, clr_wr = 1'b0, clr_wd = 1'b0;
  logic         pp_rst = 1'b0, fdef = 1'b0, q_clr = 1'b0, p_loss = 1'b0, replay = 1'b0;
  logic         nvt_v = 1'b0;
  logic [31:0]  tval = 32'h0000_0000, t0, tlog;
  logic [2:0]   read_pos = 3'h0;
  logic [7:0]   eq [8] = '{default: 8'h00};
  int           failures = 0, checked = 0;
  wire [111:0]  ctxo;
  wire [63:0]   qcat;
  wire [31:0]   read_stamp, read_stamp_hours, powered_time, power_on_time_snapshot, sv_stamp, rs_stamp;
  wire [127:0]  read_text;
  wire [15:0]   latched_faults;
  wire [7:0]    read_code, sv_code, rs_code;
  wire [2:0]    sv_pos, rs_pos;
  wire          faulted, coast_stop, read_used, sv_v, sv_u, rs_v, rs_u;
  flh_fault_log #(.TICK_CYCLES(32'h0000_0008)) u_dut (
    .sys_clk, .rst, .fault_cond, .fault_enable_mask(mask),
    .drive_status1(ctxb), .drive_status2(ctxb + 16'h0001), .alarm_status1(ctxb + 16'h0002),
    .alarm_status2(ctxb + 16'h0003), .drive_speed(ctxb + 16'h0004),
    .motor_current(ctxb + 16'h0005), .bus_volts_raw(ctxb + 16'h0006), .reset_input(rin),
    .fault_clear_wr(clr_wr), .fault_clear_wdata(clr_wd), .peripheral_port_reset(pp_rst),
    .factory_default_req(fdef), .queue_clear_req(q_clr), .power_loss(p_loss),
    .nv_restore_valid(rs_v), .nv_restore_pos(rs_pos), .nv_restore_code(rs_code),
    .nv_restore_stamp(rs_stamp), .nv_restore_used(rs_u), .nv_timer_restore_valid(nvt_v),
    .nv_timer_restore_value(tval), .read_pos, .faulted,
    .coast_stop, .latched_faults, .ctx_status1(ctxo[15:0]),
    .ctx_status2(ctxo[31:16]), .ctx_alarm1(ctxo[47:32]), .ctx_alarm2(ctxo[63:48]),
    .ctx_speed(ctxo[79:64]), .ctx_current(ctxo[95:80]), .ctx_bus_volts(ctxo[111:96]),
    .queue_code_1(qcat[7:0]), .queue_code_2(qcat[15:8]), .queue_code_3(qcat[23:16]),
    .queue_code_4(qcat[31:24]), .queue_code_5(qcat[39:32]), .queue_code_6(qcat[47:40]),
    .queue_code_7(qcat[55:48]), .queue_code_8(qcat[63:56]), .read_code,
    .read_stamp, .read_stamp_hours, .read_used, .read_text, .powered_time,
    .power_on_time_snapshot, .nv_save_valid(sv_v),
    .nv_save_pos(sv_pos), .nv_save_code(sv_code), .nv_save_stamp(sv_stamp),
    .nv_save_used(sv_u), .nv_save_done());
  flh_nv_model u_nv (
    .sys_clk, .replay, .nv_save_valid(sv_v), .nv_save_pos(sv_pos),
    .nv_save_code(sv_code), .nv_save_stamp(sv_stamp), .nv_save_used(sv_u),
    .nv_restore_valid(rs_v), .nv_restore_pos(rs_pos), .nv_restore_code(rs_code),
    .nv_restore_stamp(rs_stamp), .nv_restore_used(rs_u));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic chk_val(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic push(input logic [7:0] c);
    for (int i = 7; i > 0; i--) eq[i] = eq[i-1];
    eq[0] = c;
  endtask : push
  task automatic chk_q;
    for (int i = 0; i < 8; i++) chk_val(qcat[i*8+:8], eq[i]);
  endtask : chk_q
  task automatic chk_ctx;
    for (int k = 0; k < 7; k++) chk_val(ctxo[k*16+:16], cb + 16'(k));
  endtask : chk_ctx
  // one-cycle pulse; model queue grows only when nothing latched
  task automatic fault(input int i);
    if (mask[i] && faulted !== 1'b1) push(8'(i + 1));
    fault_cond = 16'h0001 << i;
    tick(1);
    fault_cond = 16'h0000;
  endtask : fault
  // kinds 0..3 reset the latch; 4 writes zero and must be refused
  task automatic clear(input int k);
    case (k)
      0: rin = 1'b1;
      1: {clr_wr, clr_wd} = 2'b11;
      2: pp_rst = 1'b1;
      3: fdef = 1'b1;
      default: {clr_wr, clr_wd} = 2'b10;
    endcase
    tick(1);
    {rin, clr_wr, clr_wd, pp_rst, fdef} = 5'h00;
  endtask : clear
  task automatic results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    #(25 * 3000);
    failures++;
    results();
  end
  initial begin
    tick(4);
    rst = 1'b0;
    tick(2);
    chk_val(faulted, 1'b0);
    chk_val(power_on_time_snapshot, 32'h0000_0000);
    t0 = powered_time;
    tick(80);
    chk_val(powered_time, t0 + 32'h0000_000A);
    tlog = powered_time;
    cb = ctxb;
    fault(2);
    chk_val({faulted, coast_stop}, 2'b11);
    ctxb = 16'h2000;
    tick(1);
    chk_val(read_code, 8'h03);
    chk_val(read_stamp, tlog);
    chk_val(read_stamp_hours, 32'((64'(tlog) * 35) / 36));
    chk_val(read_text, "Fault code 0x03 ");
    tick(5);
    chk_val(faulted, 1'b1);
    fault(5);
    chk_q();
    chk_ctx();
    clear(4);
    chk_val(faulted, 1'b1);
    clear(2);
    chk_val(faulted, 1'b0);
    chk_q();
    for (int i = 0; i < 10; i++) begin
      fault(i);
      clear(i % 4);
      chk_val(faulted, 1'b0);
    end
    chk_q();
    for (int p = 0; p < 8; p++) begin
      read_pos = 3'(p);
      tick(2);
      chk_val(read_code, eq[p]);
    end
    fault_cond = 16'h0080;
    push(8'h08);
    tick(1);
    push(8'h08);
    clear(2);
    chk_val(faulted, 1'b1);
    chk_q();
    fault_cond = 16'h0000;
    clear(3);
    mask = 16'hFDFF;
    tick(1);
    fault(9);
    chk_val({faulted, latched_faults}, 17'h00000);
    chk_q();
    mask = 16'hFFFF;
    p_loss = 1'b1;
    tick(1);
    p_loss = 1'b0;
    tick(12);
    rst = 1'b1;
    tick(2);
    tval = 32'h0000_1234;
    nvt_v = 1'b1;
    rst = 1'b0;
    tick(1);
    nvt_v = 1'b0;
    replay <= 1'b1;
    tick(1);
    replay <= 1'b0;
    tick(12);
    chk_val(power_on_time_snapshot, 32'h0000_1234);
    chk_val(faulted, 1'b0);
    chk_q();
    fault(1);
    q_clr = 1'b1;
    tick(1);
    q_clr = 1'b0;
    tick(1);
    chk_val(qcat, 64'h0);
    chk_val({faulted, read_used}, 2'b10);
    chk_val(read_text, "No fault        ");
    results();
  end
endmodule : tb
